//--- rtl/refresh_interval_timer.sv
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - eight-bit up-counter, readable and writable, steps on each selected tick
// - counter equal to constant sets match flag and clears counter together
// - match flag sits in control/status bit 7, reads one after a match
// - flag clears by read-while-one then write zero, or by any standby; writing one ignored
// - bit 6 enable gates the match interrupt with the flag
// - interrupt enable forced to zero while any memory enable is set
// - clock select bits 5..3: stop, or clock over 2 to 4096
// - in dram or pseudo-static mode each compare match issues one refresh request
// - in interval mode matches give periodic interrupts
// - clock select writes ignored while any memory enable is set
// - counter and constant writes ignored while any memory enable is set
// - control/status bits 2..0 always read one, writes ignored
// - counter cleared by reset and both standby modes
// - constant set to all ones by reset and hardware standby only
// - flag and enable cleared in any standby; select kept in software standby
// - both memory enables clear means interval timer, no refresh
// - memory enable pair decodes interval, dram, pseudo-static, or illegal
// - flag may still be cleared by zero write while memory enabled
module refresh_interval_timer
  import refresh_timer_pkg::*;
#(
  parameter int PRESCALE_W = PRESC_W
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sw_standby,
  input  wire logic        hw_standby,
  output logic             match_interrupt,
  output logic             refresh_request,
  output logic             pseudo_static_ram_enable,
  output logic             dynamic_ram_enable
);
  import refresh_timer_pkg::*;

  ahb_addr_s   ap_ff;
  ahb_addr_s   nxt_ap;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic        hreadyout_ff;
  logic        hresp_ff;

  logic [7:0]  count_ff;
  logic [7:0]  nxt_count;
  logic [7:0]  const_ff;
  logic [7:0]  nxt_const;
  logic [2:0]  clk_sel_ff;
  logic [2:0]  nxt_clk_sel;
  logic        flag_ff;
  logic        nxt_flag;
  logic        irq_en_ff;
  logic        nxt_irq_en;
  logic        armed_ff;
  logic        nxt_armed;
  logic        psram_en_ff;
  logic        dram_en_ff;
  logic        nxt_psram_en;
  logic        nxt_dram_en;
  logic        irq_ff;
  logic        nxt_irq;
  logic        refresh_ff;
  logic        nxt_refresh;

  wire               addr_take;
  wire [HIT_W-1:0]   rd_hit;
  wire               wr_ok;
  wire               wr_cs;
  wire               wr_count;
  wire               wr_const;
  wire               wr_mem;
  wire [DATA_W-1:0]  wdata;
  wire               standby_any;
  wire               mem_on;
  wire               match;
  wire               tick;
  wire               clear_req;
  timer_mode_e       mode;
  ctrl_status_s      cs_view;
  wire [31:0]        read_mux;

  function automatic logic [HIT_W-1:0] reg_hit(input logic [31:0] a);
    logic [HIT_W-1:0] h;
    h = '0;
    if (a == OFS_CTRL_STATUS)
      h[HIT_CS] = 1'b1;
    else if (a == OFS_COUNT)
      h[HIT_COUNT] = 1'b1;
    else if (a == OFS_TIME_CONST)
      h[HIT_CONST] = 1'b1;
    else if (a == OFS_MEM_ENABLE)
      h[HIT_MEM] = 1'b1;
    reg_hit = h;
  endfunction

  // address phase capture; unmapped addresses hit nothing and read zero
  assign addr_take = hsel & hready & htrans[1];
  assign nxt_ap    = '{valid: addr_take,
                       write: hwrite,
                       word:  (hsize == HSIZE_WORD),
                       hit:   reg_hit(haddr)};
  assign rd_hit    = (addr_take & ~hwrite) ? reg_hit(haddr) : '0;

  // writes land in the data phase; sub-word writes are dropped
  assign wr_ok    = ap_ff.valid & ap_ff.write & ap_ff.word;
  assign wr_cs    = wr_ok & ap_ff.hit[HIT_CS];
  assign wr_count = wr_ok & ap_ff.hit[HIT_COUNT];
  assign wr_const = wr_ok & ap_ff.hit[HIT_CONST];
  assign wr_mem   = wr_ok & ap_ff.hit[HIT_MEM];
  assign wdata    = hwdata[DATA_W-1:0];

  assign standby_any = sw_standby | hw_standby;
  assign mem_on      = psram_en_ff | dram_en_ff;

  assign mode = (psram_en_ff & dram_en_ff) ? MODE_ILLEGAL :
                psram_en_ff                ? MODE_PSRAM   :
                dram_en_ff                 ? MODE_DRAM    : MODE_INTERVAL;

  assign match = (count_ff == const_ff);

  assign cs_view = '{flag:    flag_ff,
                     irq_en:  irq_en_ff,
                     clk_sel: clk_sel_ff,
                     rsvd:    RSVD_ONES};

  assign read_mux =
    rd_hit[HIT_CS]    ? {24'h00_0000, cs_view}  :
    rd_hit[HIT_COUNT] ? {24'h00_0000, count_ff} :
    rd_hit[HIT_CONST] ? {24'h00_0000, const_ff} :
    rd_hit[HIT_MEM]   ? {29'h0000_0000, (mode == MODE_ILLEGAL),
                         psram_en_ff, dram_en_ff} : 32'h0000_0000;
  assign nxt_hrdata = read_mux;

  // flag clear needs earlier read while one
  // zero write clears even with memory enabled
  assign clear_req = wr_cs & ~wdata[BIT_FLAG] & armed_ff;

  // standby and match clear the counter
  // counter write blocked in memory mode
  assign nxt_count = standby_any            ? COUNT_RST :
                     match                  ? COUNT_RST :
                     (wr_count & ~mem_on)   ? wdata     :
                     tick                   ? count_ff + 8'h01 : count_ff;

  // constant write blocked in memory mode
  assign nxt_const = hw_standby             ? CONST_RST :
                     (wr_const & ~mem_on)   ? wdata     : const_ff;

  // select write blocked in memory mode
  assign nxt_clk_sel = hw_standby           ? SEL_RST :
                       (wr_cs & ~mem_on)    ? wdata[SEL_HI:SEL_LO] : clk_sel_ff;

  // enable forced low in memory mode
  assign nxt_irq_en = (standby_any | mem_on) ? 1'b0 :
                      wr_cs ? wdata[BIT_IRQ_EN] : irq_en_ff;

  // set wins over a clear in the same cycle
  assign nxt_flag = standby_any ? 1'b0 :
                    match       ? 1'b1 :
                    clear_req   ? 1'b0 : flag_ff;

  // a write to the status register disarms unless a read of it with the flag at one starts that cycle, so a stale read cannot clear
  assign nxt_armed = standby_any                 ? 1'b0 :
                     (rd_hit[HIT_CS] & flag_ff)  ? 1'b1 :
                     wr_cs                       ? 1'b0 : armed_ff;

  // enable bits stay writable so software can leave memory mode
  assign nxt_psram_en = hw_standby ? 1'b0 :
                        wr_mem ? wdata[BIT_PSRAM] : psram_en_ff;
  assign nxt_dram_en  = hw_standby ? 1'b0 :
                        wr_mem ? wdata[BIT_DRAM] : dram_en_ff;

  // level and of next flag and enable
  assign nxt_irq = nxt_flag & nxt_irq_en;

  assign nxt_refresh = match & ~standby_any &
                       ((mode == MODE_DRAM) | (mode == MODE_PSRAM));

  refresh_prescaler #(
    .WIDTH   (PRESCALE_W)
  ) u_prescaler (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (standby_any),
    .clk_sel (clk_sel_ff),
    .tick    (tick)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_ff        <= '0;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= HRESP_OKAY;
    end
    else
    begin
      ap_ff        <= nxt_ap;
      hrdata_ff    <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= HRESP_OKAY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_ff   <= COUNT_RST;
      const_ff   <= CONST_RST;
      clk_sel_ff <= SEL_RST;
      flag_ff    <= 1'b0;
      irq_en_ff  <= 1'b0;
      armed_ff   <= 1'b0;
    end
    else
    begin
      count_ff   <= nxt_count;
      const_ff   <= nxt_const;
      clk_sel_ff <= nxt_clk_sel;
      flag_ff    <= nxt_flag;
      irq_en_ff  <= nxt_irq_en;
      armed_ff   <= nxt_armed;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      psram_en_ff <= 1'b0;
      dram_en_ff  <= 1'b0;
      irq_ff      <= 1'b0;
      refresh_ff  <= 1'b0;
    end
    else
    begin
      psram_en_ff <= nxt_psram_en;
      dram_en_ff  <= nxt_dram_en;
      irq_ff      <= nxt_irq;
      refresh_ff  <= nxt_refresh;
    end
  end

  assign hrdata                   = hrdata_ff;
  assign hreadyout                = hreadyout_ff;
  assign hresp                    = hresp_ff;
  assign match_interrupt          = irq_ff;
  assign refresh_request          = refresh_ff;
  assign pseudo_static_ram_enable = psram_en_ff;
  assign dynamic_ram_enable       = dram_en_ff;

  a_match_clears: assert property (
    @(posedge hclk) disable iff (!hresetn)
    match && !standby_any |=> count_ff == COUNT_RST && flag_ff)
    else $error("match did not clear counter and set flag");

  a_flag_readback: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_hit[HIT_CS] |=> hrdata_ff[BIT_FLAG] == $past(flag_ff))
    else $error("flag not seen in bit 7");

  a_flag_one_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_cs && wdata[BIT_FLAG] && flag_ff && !standby_any |=> flag_ff)
    else $error("writing one changed the flag");

  a_flag_clear_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(flag_ff) |-> $past(clear_req) || $past(standby_any))
    else $error("flag cleared without read then zero write");

  a_irq_and: assert property (
    @(posedge hclk) disable iff (!hresetn)
    match_interrupt == (flag_ff && irq_en_ff))
    else $error("interrupt not equal to flag and enable");

  a_irq_en_forced: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mem_on |=> !irq_en_ff)
    else $error("enable set while memory enabled");

  a_sel_locked: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mem_on && !hw_standby |=> $stable(clk_sel_ff))
    else $error("clock select changed in memory mode");

  a_const_locked: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mem_on && !hw_standby |=> $stable(const_ff))
    else $error("constant changed in memory mode");

  a_rsvd_ones: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_hit[HIT_CS] |=> hrdata_ff[RSVD_HI:RSVD_LO] == RSVD_ONES)
    else $error("reserved bits not ones");

  a_standby_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    standby_any |=> count_ff == COUNT_RST && !flag_ff && !irq_en_ff)
    else $error("standby did not clear counter state");

  a_sw_standby_keep: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sw_standby && !hw_standby && !wr_ok
      |=> $stable(clk_sel_ff) && $stable(const_ff))
    else $error("software standby lost select or constant");

  a_hw_standby_init: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hw_standby |=> const_ff == CONST_RST && clk_sel_ff == SEL_RST)
    else $error("hardware standby did not initialise");

  a_refresh_pulse: assert property (
    @(posedge hclk) disable iff (!hresetn)
    refresh_request |-> $past(match) && $past(mem_on))
    else $error("refresh request without match");

  a_interval_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == MODE_INTERVAL |=> !refresh_request)
    else $error("refresh issued in interval mode");

  a_stopped_count: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_sel_ff == SEL_STOP && !match && !wr_count
      ##1 clk_sel_ff == SEL_STOP |-> !tick)
    else $error("counter ticked with clock input stopped");
endmodule

//--- rtl/refresh_timer_pkg.sv
package refresh_timer_pkg;

  // register byte offsets on the bus
  localparam logic [31:0] OFS_CTRL_STATUS = 32'h0000_0000;
  localparam logic [31:0] OFS_COUNT       = 32'h0000_0004;
  localparam logic [31:0] OFS_TIME_CONST  = 32'h0000_0008;
  localparam logic [31:0] OFS_MEM_ENABLE  = 32'h0000_000C;

  // one-hot decode positions
  localparam int HIT_CS    = 0;
  localparam int HIT_COUNT = 1;
  localparam int HIT_CONST = 2;
  localparam int HIT_MEM   = 3;
  localparam int HIT_W     = 4;

  // control/status field layout
  localparam int BIT_FLAG   = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int SEL_HI     = 5;
  localparam int SEL_LO     = 3;
  localparam int RSVD_HI    = 2;
  localparam int RSVD_LO    = 0;

  // memory enable register layout
  localparam int BIT_DRAM    = 0;
  localparam int BIT_PSRAM   = 1;
  localparam int BIT_ILLEGAL = 2;

  localparam int DATA_W = 8;

  // reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CONST_RST = 8'hFF;
  localparam logic [2:0] SEL_RST   = 3'h0;
  localparam logic [2:0] RSVD_ONES = 3'h7;

  // clock select codes and divider exponents
  localparam logic [2:0] SEL_STOP    = 3'h0;
  localparam logic [2:0] SEL_DIV2    = 3'h1;
  localparam logic [2:0] SEL_DIV8    = 3'h2;
  localparam logic [2:0] SEL_DIV32   = 3'h3;
  localparam logic [2:0] SEL_DIV128  = 3'h4;
  localparam logic [2:0] SEL_DIV512  = 3'h5;
  localparam logic [2:0] SEL_DIV2048 = 3'h6;
  localparam int LOG_DIV2    = 1;
  localparam int LOG_DIV8    = 3;
  localparam int LOG_DIV32   = 5;
  localparam int LOG_DIV128  = 7;
  localparam int LOG_DIV512  = 9;
  localparam int LOG_DIV2048 = 11;
  localparam int LOG_DIV4096 = 12;
  localparam int PRESC_W     = 12;

  // ahb-lite codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    MODE_INTERVAL,
    MODE_DRAM,
    MODE_PSRAM,
    MODE_ILLEGAL
  } timer_mode_e;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              word;
    logic [HIT_W-1:0]  hit;
  } ahb_addr_s;

  typedef struct packed {
    logic       flag;
    logic       irq_en;
    logic [2:0] clk_sel;
    logic [2:0] rsvd;
  } ctrl_status_s;

endpackage

//--- rtl/refresh_prescaler.sv
`timescale 1ns/1ps
module refresh_prescaler
  import refresh_timer_pkg::*;
#(
  parameter int WIDTH = PRESC_W
)(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clear,
  input  wire logic [2:0] clk_sel,
  output logic            tick
);
  import refresh_timer_pkg::*;

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic             tick_ff;
  logic             nxt_tick;
  wire  [WIDTH-1:0] mask;

  function automatic logic [WIDTH-1:0] div_mask(input logic [2:0] sel);
    int lg;
    lg = LOG_DIV4096;
    case (sel)
      SEL_DIV2:    lg = LOG_DIV2;
      SEL_DIV8:    lg = LOG_DIV8;
      SEL_DIV32:   lg = LOG_DIV32;
      SEL_DIV128:  lg = LOG_DIV128;
      SEL_DIV512:  lg = LOG_DIV512;
      SEL_DIV2048: lg = LOG_DIV2048;
      default:     lg = LOG_DIV4096;
    endcase
    div_mask = WIDTH'((32'h0000_0001 << lg) - 32'h0000_0001);
  endfunction

  assign mask    = div_mask(clk_sel);
  assign nxt_cnt = clear ? '0 : cnt_ff + 1'b1;
  assign nxt_tick = ~clear & (clk_sel != SEL_STOP) & ((cnt_ff & mask) == mask);
  assign tick     = tick_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  a_tick_single: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick_ff |=> !tick_ff) else $error("tick lasted two cycles");
endmodule

//--- verif/refresh_seq_model.sv
`timescale 1ns/1ps
module refresh_seq_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic refresh_request,
  output int        req_n,
  output int        last_gap
);
  int now_ff;
  int stamp_ff;

  // the sequencer only counts requests and measures their spacing; no cycles are run
  // periodic request intake
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      now_ff   <= 0;
      stamp_ff <= 0;
      req_n    <= 0;
      last_gap <= 0;
    end
    else
    begin
      now_ff <= now_ff + 1;
      if (refresh_request)
      begin
        req_n    <= req_n + 1;
        last_gap <= now_ff - stamp_ff;
        stamp_ff <= now_ff;
      end
    end
  end
endmodule

//--- verif/refresh_interval_timer_test.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED %s exp=%h got=%h", nm, exp, got); \
    end \
  end
module refresh_interval_timer_test;
  import refresh_timer_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sw_standby;
  logic        hw_standby;
  logic        match_interrupt;
  logic        refresh_request;
  logic        psram_en;
  logic        dram_en;
  logic        rd_pend;
  logic [31:0] exp_q[$];
  logic [31:0] exp_rd;
  logic [31:0] rnd;
  int          req_n;
  int          last_gap;
  int          n_errors;
  int          compares;
  int          cycles;
  int          seed;
  int          base;
  int          lgs[7];

  refresh_interval_timer dut (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .hsel                     (hsel),
    .haddr                    (haddr),
    .htrans                   (htrans),
    .hwrite                   (hwrite),
    .hsize                    (hsize),
    .hwdata                   (hwdata),
    .hready                   (hreadyout),
    .hrdata                   (hrdata),
    .hreadyout                (hreadyout),
    .hresp                    (hresp),
    .sw_standby               (sw_standby),
    .hw_standby               (hw_standby),
    .match_interrupt          (match_interrupt),
    .refresh_request          (refresh_request),
    .pseudo_static_ram_enable (psram_en),
    .dynamic_ram_enable       (dram_en)
  );

  refresh_seq_model seq (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .refresh_request (refresh_request),
    .req_n           (req_n),
    .last_gap        (last_gap)
  );

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // run takes about 21000 cycles; the ceiling leaves room
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  // read data are taken at the edge ending the data phase
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout === 1'b1)
    begin
      // pop once; the compare macro reads its expected value twice
      exp_rd = exp_q.pop_front();
      `CHK("hrdata", exp_rd, hrdata)
      `CHK("hresp", HRESP_OKAY, hresp)
    end
  end

  // single word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, input logic [31:0] e);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    if (!wr)
    begin
      exp_q.push_back(e);
      rd_pend <= 1'b1;
    end
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_pend <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0000_0000);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, e);
  endtask

  task automatic standby(input logic hw);
    if (hw)
      hw_standby <= 1'b1;
    else
      sw_standby <= 1'b1;
    repeat (2) @(posedge hclk);
    hw_standby <= 1'b0;
    sw_standby <= 1'b0;
    @(posedge hclk);
  endtask

  initial
  begin
    lgs = '{LOG_DIV2, LOG_DIV8, LOG_DIV32, LOG_DIV128, LOG_DIV512,
            LOG_DIV2048, LOG_DIV4096};
    seed = 83882;
    hresetn = 1'b0;
    {hsel, hwrite, rd_pend, sw_standby, hw_standby} = '0;
    haddr = '0;
    htrans = 2'b00;
    hsize = HSIZE_WORD;
    hwdata = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_CTRL_STATUS, 32'h0000_0007);
    rd(OFS_COUNT, 32'h0000_0000);
    rd(OFS_TIME_CONST, 32'h0000_00FF);
    rd(32'h0000_0010, 32'h0000_0000);
    // count kept below 0x40 and constant above 0x7f, so no stray match
    rnd = ($random(seed) & 32'h0000_3F3F) | 32'h0000_8000;
    wr(OFS_COUNT, rnd);
    rd(OFS_COUNT, {24'h0, rnd[7:0]});
    wr(OFS_TIME_CONST, rnd >> 8);
    rd(OFS_TIME_CONST, {24'h0, rnd[15:8]});
    // low three bits written as zero must still read ones
    wr(OFS_CTRL_STATUS, 32'h0000_0068);
    rd(OFS_CTRL_STATUS, 32'h0000_006F);
    standby(1'b0);
    rd(OFS_COUNT, 32'h0000_0000);
    rd(OFS_TIME_CONST, {24'h0, rnd[15:8]});
    rd(OFS_CTRL_STATUS, 32'h0000_002F);
    standby(1'b1);
    rd(OFS_CTRL_STATUS, 32'h0000_0007);
    rd(OFS_TIME_CONST, 32'h0000_00FF);
    wr(OFS_TIME_CONST, 32'h0000_0003);
    wr(OFS_CTRL_STATUS, 32'h0000_0008);
    base = req_n;
    wr(OFS_CTRL_STATUS, 32'h0000_0048);
    while (match_interrupt !== 1'b1) @(posedge hclk);
    `CHK("refresh in interval mode", base, req_n)
    wr(OFS_CTRL_STATUS, 32'h0000_0040);
    rd(OFS_CTRL_STATUS, 32'h0000_00C7);
    wr(OFS_CTRL_STATUS, 32'h0000_0040);
    rd(OFS_CTRL_STATUS, 32'h0000_0047);
    `CHK("match_interrupt", 1'b0, match_interrupt)
    wr(OFS_CTRL_STATUS, 32'h0000_00C0);
    rd(OFS_CTRL_STATUS, 32'h0000_0047);
    wr(OFS_TIME_CONST, 32'h0000_0001);
    for (int k = 1; k <= 7; k++)
    begin
      // timer registers touched only with both enables clear
      wr(OFS_MEM_ENABLE, 32'h0000_0000);
      wr(OFS_CTRL_STATUS, k << 3);
      wr(OFS_COUNT, 32'h0000_0000);
      // odd k dram, even k pseudo-static ram, same order
      wr(OFS_MEM_ENABLE, (k % 2) ? 32'h0000_0001 : 32'h0000_0002);
      base = req_n;
      while (req_n < base + 3) @(posedge hclk);
      // constant 1: the match clears at once, so one tick per request
      `CHK("refresh period", 1 << lgs[k-1], last_gap)
    end
    // blocked writes while memory mode is on, flag clear still works
    wr(OFS_TIME_CONST, 32'h0000_0020);
    rd(OFS_TIME_CONST, 32'h0000_0001);
    wr(OFS_COUNT, 32'h0000_0033);
    rd(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL_STATUS, 32'h0000_0040);
    rd(OFS_CTRL_STATUS, 32'h0000_00BF);
    wr(OFS_CTRL_STATUS, 32'h0000_0000);
    rd(OFS_CTRL_STATUS, 32'h0000_003F);
    `CHK("match_interrupt", 1'b0, match_interrupt)
    wr(OFS_MEM_ENABLE, 32'h0000_0003);
    rd(OFS_MEM_ENABLE, 32'h0000_0007);
    `CHK("memory enables", 2'b11, {psram_en, dram_en})
    wr(OFS_MEM_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    print_verdict();
  end
endmodule
